//--- hdl/ecm_pkg.sv
// shared constants and types of the converter group control block
package ecm_pkg;
  // register byte offsets (wishbone word aligned)
  localparam logic [7:0] ECM_OFF_ANALOG_CFG  = 8'h00;
  localparam logic [7:0] ECM_OFF_ARB_CFG     = 8'h04;
  localparam logic [7:0] ECM_OFF_GLOBAL_CFG  = 8'h08;
  localparam logic [7:0] ECM_OFF_ARB_PRIO    = 8'h0C;
  localparam logic [7:0] ECM_OFF_QMODE0      = 8'h10;
  localparam logic [7:0] ECM_OFF_ICLASS0     = 8'h14;
  localparam logic [7:0] ECM_OFF_RCTRL0      = 8'h18;
  localparam logic [7:0] ECM_OFF_QINPUT0     = 8'h1C;
  localparam logic [7:0] ECM_OFF_RESULT0     = 8'h20;
  localparam logic [7:0] ECM_OFF_FIFO        = 8'h24;
  localparam logic [7:0] ECM_OFF_IRQ_STAT    = 8'h28;
  localparam logic [7:0] ECM_OFF_IRQ_MASK    = 8'h2C;
  // field positions
  localparam int ECM_BIT_ANON      = 0;   // arb cfg: analog block on (two bits)
  localparam int ECM_BIT_CAL_ACT   = 28;  // arb cfg: calibration active flag
  localparam int ECM_BIT_SUCAL     = 31;  // global cfg: start calibration
  localparam int ECM_BIT_SLOT0     = 24;  // arb prio: slot 0 enable
  localparam int ECM_BIT_SRC0_EN   = 0;   // queue mode: source enable
  localparam int ECM_BIT_RSRV_EN   = 31;  // result control: service req enable
  localparam int ECM_BIT_RPT       = 5;   // queue input: auto repeat
  localparam int ECM_LSB_STC       = 0;   // input class: sample time field
  localparam int ECM_LSB_AIP       = 8;   // input class: precharge select field
  localparam int ECM_BIT_BUF_EN    = 10;  // input class: buffer enable
  localparam int ECM_LSB_ANDIV     = 20;  // analog cfg: clock divider field
  // reset values
  localparam logic [31:0] ECM_RST_ZERO    = 32'h0000_0000;
  localparam logic [31:0] ECM_RST_ANALOG  = 32'h0030_0000;
  // timing
  localparam int ECM_CLK_MHZ         = 250;
  localparam int ECM_WAKE_NS         = 5000;
  localparam int ECM_WAKE_CYC        = (ECM_WAKE_NS * ECM_CLK_MHZ + 999) / 1000;
  localparam int ECM_CAL_NS          = 4000;
  localparam int ECM_CAL_CYC         = (ECM_CAL_NS * ECM_CLK_MHZ + 999) / 1000;
  localparam int ECM_CONV_CYC        = 20;
  localparam int ECM_FIFO_LAT_CYC    = 12;  // 6 bus + 6 converter cycles
  localparam int ECM_FIFO_GAP_CYC    = 7;   // 1 bus + 6 converter cycles
  localparam logic [5:0] ECM_PRE_8   = 6'h08;
  localparam logic [5:0] ECM_PRE_16  = 6'h10;
  localparam logic [5:0] ECM_PRE_32  = 6'h20;
  localparam int ECM_FIFO_DEPTH      = 4;
  // interrupt status bits
  localparam int ECM_IRQ_RESULT = 0;
  localparam int ECM_IRQ_CALDONE = 1;
  localparam int ECM_IRQ_OVR    = 2;

  typedef enum logic [3:0] {
    ECM_ST_OFF    = 4'b0001,
    ECM_ST_IDLE   = 4'b0010,
    ECM_ST_CAL    = 4'b0100,
    ECM_ST_READY  = 4'b1000
  } ecm_state_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ecm_wb_req_s;

  typedef struct packed {
    logic        buf_drive;
    logic        sample;
    logic        done;
  } ecm_samp_s;
endpackage

//--- hdl/ecm_sampler.sv
// sample phase sequencer with buffered precharge
`timescale 1ns/1ps
module ecm_sampler
  import ecm_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      nrst,
  input  wire logic      ce,
  input  wire logic      start,
  input  wire logic      buf_en,
  input  wire logic [1:0] aip_sel,
  input  wire logic [4:0] sample_time_control,
  output ecm_samp_s      samp
);
  logic [7:0] cnt_q, cnt_d;
  logic [5:0] pre_q, pre_d;
  logic       act_q, act_d;
  logic [5:0] pre_len;
  logic [7:0] tot_len;

  always_comb begin
    if (aip_sel == 2'h0) begin
      pre_len = ECM_PRE_8;
    end else if (aip_sel == 2'h1) begin
      pre_len = ECM_PRE_16;
    end else begin
      pre_len = ECM_PRE_32;
    end
    // sample time in converter clocks: 2 + stc, at least the precharge
    tot_len = 8'(sample_time_control) + 8'h02;
    if (buf_en && tot_len < {2'h0, pre_len}) begin
      tot_len = {2'h0, pre_len};
    end
    act_d = act_q;
    cnt_d = cnt_q;
    pre_d = pre_q;
    if (start && !act_q) begin
      act_d = 1'b1;
      cnt_d = tot_len;
      pre_d = buf_en ? pre_len : 6'h00; // [RL12]
    end else if (act_q) begin
      cnt_d = cnt_q - 8'h01;
      if (pre_q != 6'h00) begin
        pre_d = pre_q - 6'h01; // [RL13]
      end
      if (cnt_q == 8'h01) begin
        act_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      act_q <= 1'b0;
      cnt_q <= 8'h00;
      pre_q <= 6'h00;
    end else if (ce) begin
      act_q <= act_d;
      cnt_q <= cnt_d;
      pre_q <= pre_d;
    end
  end

  assign samp.buf_drive = act_q && (pre_q != 6'h00);
  assign samp.sample    = act_q;
  assign samp.done      = act_q && (cnt_q == 8'h01);
endmodule

//--- hdl/ecm_fifo.sv
// result fifo with paced read side
`timescale 1ns/1ps
module ecm_fifo
  import ecm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        push,
  input  wire logic [15:0] push_dat,
  input  wire logic        pop,
  output logic      [15:0] top_dat,
  output logic             empty,
  output logic             full
);
  logic [15:0] mem_q [ECM_FIFO_DEPTH];
  logic [15:0] mem_d [ECM_FIFO_DEPTH];
  logic [2:0]  cnt_q, cnt_d;

  always_comb begin
    mem_d = mem_q;
    cnt_d = cnt_q;
    if (pop && cnt_q != 3'h0) begin
      for (int i = 0; i < ECM_FIFO_DEPTH - 1; i++) begin
        mem_d[i] = mem_q[i + 1];
      end
      cnt_d = cnt_q - 3'h1;
    end
    if (push) begin
      if (cnt_d == 3'(ECM_FIFO_DEPTH)) begin
        mem_d[ECM_FIFO_DEPTH - 1] = push_dat;
      end else begin
        mem_d[cnt_d[1:0]] = push_dat;
        cnt_d = cnt_d + 3'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cnt_q <= 3'h0;
      for (int i = 0; i < ECM_FIFO_DEPTH; i++) begin
        mem_q[i] <= 16'h0000;
      end
    end else if (ce) begin
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end

  assign top_dat = mem_q[0];
  assign empty   = (cnt_q == 3'h0);
  assign full    = (cnt_q == 3'(ECM_FIFO_DEPTH));
endmodule

//--- hdl/ecm_group.sv
// converter group control: init sequence, conversion, result fifo, wishbone slave
// ============================================================
// Functional notes
// [RL1] software divides converter clock to analog clock through analog config
// [RL2] writing 3 to arbitration config powers the analog block
// [RL3] software waits at least the wakeup time before calibration
// [RL4] writing the top bit of global config starts calibration
// [RL5] writing bit 24 of arbitration priority enables slot 0
// [RL6] writing 1 to queue mode enables request source 0
// [RL7] writing 2 to input class 0 selects four-clock sampling
// [RL8] results go to result register 0 and service line 0
// [RL9] top bit of result control enables result service requests
// [RL10] writing 0x20 to queue input requests channel 0 auto-repeat
// [RL11] calibration done after calibration time; active flag then reads zero
// [RL12] buffered precharge lasts 8, 16 or 32 clocks when enabled
// [RL13] after precharge sampling continues directly from the input
// [RL14] software sets sample time covering precharge and direct phase
// [RL15] software uses 32-clock precharge at 160 MHz
// [RL16] fifo read answers after 6 bus plus 6 converter cycles
// [RL17] reader spaces fifo reads by 1 bus plus 6 converter cycles
// [RL18] reader preferably reads fifo after the service request
// [RL19] conversions wait while calibrating; flag clears as calibration ends
`timescale 1ns/1ps
module ecm_group
  import ecm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  ecm_wb_req_s      wb_req,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] conv_data,
  output logic             analog_on,
  output logic             buf_drive,
  output logic             sampling,
  output logic             service_req0,
  output logic             irq
);
  // ============================================================
  // registers
  logic [31:0] analog_cfg_q, analog_cfg_d;
  logic [1:0]  anon_q, anon_d;
  logic        slot0_q, slot0_d;
  logic        src0_q, src0_d;
  logic [10:0] iclass_q, iclass_d;
  logic        rsrv_q, rsrv_d;
  logic        rpt_q, rpt_d;
  logic        pend_q, pend_d;
  logic [15:0] result_q, result_d;
  logic [2:0]  ist_q, ist_d;
  logic [2:0]  imask_q, imask_d;
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic        srv_q, srv_d;
  // ============================================================
  // sequencer state
  ecm_state_e  st_q, st_d;
  logic [15:0] tmr_q, tmr_d;
  logic        wake_ok_q, wake_ok_d;
  logic [4:0]  fifo_lat_q, fifo_lat_d;
  logic [3:0]  fifo_gap_q, fifo_gap_d;
  logic        conv_start;
  logic        cal_done;
  logic        fifo_pop;
  logic        fifo_ovr;
  logic [15:0] fifo_top;
  logic        fifo_empty;
  logic        fifo_full;
  ecm_samp_s   samp;
  logic        wr;
  logic        rd;
  logic        fifo_rd;

  assign wr = wb_req.cyc && wb_req.stb && wb_req.we && !ack_q;
  assign rd = wb_req.cyc && wb_req.stb && !wb_req.we && !ack_q;
  assign fifo_rd = rd && (wb_req.adr == ECM_OFF_FIFO);

  // ============================================================
  // calibration and conversion sequencing
  always_comb begin
    st_d      = st_q;
    tmr_d     = tmr_q;
    wake_ok_d = wake_ok_q;
    cal_done  = 1'b0;
    case (st_q)
      ECM_ST_OFF: begin
        tmr_d = 16'h0000;
        wake_ok_d = 1'b0;
        if (anon_q == 2'h3) begin
          st_d = ECM_ST_IDLE;
        end
      end
      ECM_ST_IDLE: begin
        if (tmr_q != 16'(ECM_WAKE_CYC)) begin
          tmr_d = tmr_q + 16'h0001;
        end else begin
          wake_ok_d = 1'b1;
        end
        if (wr && wb_req.adr == ECM_OFF_GLOBAL_CFG && wb_req.dat[ECM_BIT_SUCAL]) begin
          st_d  = ECM_ST_CAL; // [RL4]
          tmr_d = 16'h0000;
        end
      end
      ECM_ST_CAL: begin
        tmr_d = tmr_q + 16'h0001;
        if (tmr_q == 16'(ECM_CAL_CYC - 1)) begin
          cal_done = 1'b1; // [RL11]
          st_d     = ECM_ST_READY;
        end
      end
      ECM_ST_READY: begin
        tmr_d = 16'h0000;
      end
      default: begin
        st_d = ECM_ST_OFF;
      end
    endcase
    if (anon_q != 2'h3) begin
      st_d = ECM_ST_OFF;
    end
  end

  // conversions only run after calibration with slot and source enabled
  assign conv_start = (st_q == ECM_ST_READY) && slot0_q && src0_q && pend_q
                      && !samp.sample; // [RL19] [RL10]

  // ============================================================
  // register writes and status
  always_comb begin
    analog_cfg_d = analog_cfg_q;
    anon_d   = anon_q;
    slot0_d  = slot0_q;
    src0_d   = src0_q;
    iclass_d = iclass_q;
    rsrv_d   = rsrv_q;
    rpt_d    = rpt_q;
    pend_d   = pend_q;
    result_d = result_q;
    imask_d  = imask_q;
    ist_d    = ist_q;
    srv_d    = 1'b0;
    if (wr) begin
      if (wb_req.adr == ECM_OFF_ANALOG_CFG) begin
        analog_cfg_d = wb_req.dat; // [RL1]
      end else if (wb_req.adr == ECM_OFF_ARB_CFG) begin
        anon_d = wb_req.dat[ECM_BIT_ANON +: 2]; // [RL2]
      end else if (wb_req.adr == ECM_OFF_ARB_PRIO) begin
        slot0_d = wb_req.dat[ECM_BIT_SLOT0]; // [RL5]
      end else if (wb_req.adr == ECM_OFF_QMODE0) begin
        src0_d = wb_req.dat[ECM_BIT_SRC0_EN]; // [RL6]
      end else if (wb_req.adr == ECM_OFF_ICLASS0) begin
        iclass_d = wb_req.dat[10:0]; // [RL7]
      end else if (wb_req.adr == ECM_OFF_RCTRL0) begin
        rsrv_d = wb_req.dat[ECM_BIT_RSRV_EN]; // [RL9]
      end else if (wb_req.adr == ECM_OFF_QINPUT0) begin
        rpt_d  = wb_req.dat[ECM_BIT_RPT];
        pend_d = 1'b1; // [RL10]
      end else if (wb_req.adr == ECM_OFF_IRQ_MASK) begin
        imask_d = wb_req.dat[2:0];
      end else if (wb_req.adr == ECM_OFF_IRQ_STAT) begin
        ist_d = ist_q & ~wb_req.dat[2:0];
      end
    end
    if (samp.done) begin
      result_d = conv_data; // [RL8]
      if (!rpt_q) begin
        pend_d = 1'b0;
      end
      srv_d = rsrv_q; // [RL9] [RL8]
      ist_d[ECM_IRQ_RESULT] = 1'b1;
    end
    if (cal_done) begin
      ist_d[ECM_IRQ_CALDONE] = 1'b1;
    end
    if (fifo_ovr) begin
      ist_d[ECM_IRQ_OVR] = 1'b1;
    end
  end

  assign fifo_ovr = samp.done && fifo_full && !fifo_pop;

  // ============================================================
  // wishbone answers, fifo reads paced by latency counter
  always_comb begin
    ack_d      = 1'b0;
    rdat_d     = rdat_q;
    fifo_lat_d = fifo_lat_q;
    fifo_gap_d = (fifo_gap_q != 4'h0) ? fifo_gap_q - 4'h1 : 4'h0;
    fifo_pop   = 1'b0;
    if (fifo_rd) begin
      if (fifo_lat_q == 5'h00 && fifo_gap_q == 4'h0) begin
        // ack registers one edge after the count ends, so load one less
        fifo_lat_d = 5'(ECM_FIFO_LAT_CYC - 1); // [RL16]
      end else if (fifo_lat_q == 5'h01) begin
        fifo_lat_d = 5'h00;
        ack_d      = 1'b1;
        rdat_d     = {16'h0000, fifo_top};
        fifo_pop   = 1'b1;
        fifo_gap_d = 4'(ECM_FIFO_GAP_CYC); // [RL17]
      end else if (fifo_lat_q != 5'h00) begin
        fifo_lat_d = fifo_lat_q - 5'h01;
      end
    end else if (rd) begin
      ack_d = 1'b1;
      if (wb_req.adr == ECM_OFF_ANALOG_CFG) begin
        rdat_d = analog_cfg_q;
      end else if (wb_req.adr == ECM_OFF_ARB_CFG) begin
        rdat_d = {3'h0, st_q == ECM_ST_CAL, 26'h0, anon_q}; // [RL11]
      end else if (wb_req.adr == ECM_OFF_ARB_PRIO) begin
        rdat_d = {7'h0, slot0_q, 24'h0};
      end else if (wb_req.adr == ECM_OFF_QMODE0) begin
        rdat_d = {31'h0, src0_q};
      end else if (wb_req.adr == ECM_OFF_ICLASS0) begin
        rdat_d = {21'h0, iclass_q};
      end else if (wb_req.adr == ECM_OFF_RCTRL0) begin
        rdat_d = {rsrv_q, 31'h0};
      end else if (wb_req.adr == ECM_OFF_QINPUT0) begin
        rdat_d = {26'h0, rpt_q, 5'h00};
      end else if (wb_req.adr == ECM_OFF_RESULT0) begin
        rdat_d = {16'h0000, result_q};
      end else if (wb_req.adr == ECM_OFF_IRQ_STAT) begin
        rdat_d = {29'h0, ist_q};
      end else if (wb_req.adr == ECM_OFF_IRQ_MASK) begin
        rdat_d = {29'h0, imask_q};
      end else begin
        rdat_d = 32'h0000_0000;
      end
    end else if (wr) begin
      ack_d = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      analog_cfg_q <= ECM_RST_ANALOG;
      anon_q     <= 2'h0;
      slot0_q    <= 1'b0;
      src0_q     <= 1'b0;
      iclass_q   <= 11'h000;
      rsrv_q     <= 1'b0;
      rpt_q      <= 1'b0;
      pend_q     <= 1'b0;
      result_q   <= 16'h0000;
      ist_q      <= 3'h0;
      imask_q    <= 3'h0;
      ack_q      <= 1'b0;
      rdat_q     <= ECM_RST_ZERO;
      srv_q      <= 1'b0;
      st_q       <= ECM_ST_OFF;
      tmr_q      <= 16'h0000;
      wake_ok_q  <= 1'b0;
      fifo_lat_q <= 5'h00;
      fifo_gap_q <= 4'h0;
    end else if (ce) begin
      analog_cfg_q <= analog_cfg_d;
      anon_q     <= anon_d;
      slot0_q    <= slot0_d;
      src0_q     <= src0_d;
      iclass_q   <= iclass_d;
      rsrv_q     <= rsrv_d;
      rpt_q      <= rpt_d;
      pend_q     <= pend_d;
      result_q   <= result_d;
      ist_q      <= ist_d;
      imask_q    <= imask_d;
      ack_q      <= ack_d;
      rdat_q     <= rdat_d;
      srv_q      <= srv_d;
      st_q       <= st_d;
      tmr_q      <= tmr_d;
      wake_ok_q  <= wake_ok_d;
      fifo_lat_q <= fifo_lat_d;
      fifo_gap_q <= fifo_gap_d;
    end
  end

  // ============================================================
  // sub blocks
  ecm_sampler u_sampler (
    .clock   (clock),
    .nrst    (nrst),
    .ce      (ce),
    .start   (conv_start),
    .buf_en  (iclass_q[ECM_BIT_BUF_EN]),
    .aip_sel (iclass_q[ECM_LSB_AIP +: 2]),
    .sample_time_control     (iclass_q[ECM_LSB_STC +: 5]),
    .samp    (samp)
  );

  ecm_fifo u_fifo (
    .clock    (clock),
    .nrst     (nrst),
    .ce       (ce),
    .push     (samp.done),
    .push_dat (conv_data),
    .pop      (fifo_pop),
    .top_dat  (fifo_top),
    .empty    (fifo_empty),
    .full     (fifo_full)
  );

  assign wb_dat_o     = rdat_q;
  assign wb_ack_o     = ack_q;
  assign analog_on    = (anon_q == 2'h3);
  assign buf_drive    = samp.buf_drive; // [RL12]
  assign sampling     = samp.sample;
  assign service_req0 = srv_q;
  assign irq          = |(ist_q & imask_q);
endmodule

//--- verification/ecm_group_sva.sv
// concurrent checks on the converter group control ports
`timescale 1ns/1ps
module ecm_group_sva
  import ecm_pkg::*;
(
  input wire logic  clock,
  input wire logic  nrst,
  input ecm_wb_req_s wb_req,
  input wire logic  wb_ack_o,
  input wire logic  analog_on,
  input wire logic  buf_drive,
  input wire logic  sampling,
  input wire logic  service_req0
);
  // ============================================================
  // helper: length of the buffered phase
  logic [5:0] buf_cnt_q;
  logic [5:0] buf_cnt_d;

  always_comb begin
    buf_cnt_d = buf_drive ? buf_cnt_q + 6'h01 : 6'h00;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      buf_cnt_q <= 6'h00;
    end else begin
      buf_cnt_q <= buf_cnt_d;
    end
  end

  // ============================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_reg_ack_lat: assert property (($rose(wb_req.stb) && wb_req.cyc && wb_req.adr != ECM_OFF_FIFO)
    |=> wb_ack_o) else $error("register access not answered in one cycle");
  a_fifo_ack_wait: assert property (($rose(wb_req.stb) && wb_req.cyc && !wb_req.we &&
    wb_req.adr == ECM_OFF_FIFO) |=> !wb_ack_o [*8]) else $error("fifo read answered early");
  a_fifo_ack_lat: assert property (($rose(wb_req.stb) && wb_req.cyc && !wb_req.we &&
    wb_req.adr == ECM_OFF_FIFO) |-> ##12 wb_ack_o) else $error("fifo read latency wrong");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_power_up: assert property ((wb_ack_o && wb_req.we && wb_req.adr == ECM_OFF_ARB_CFG &&
    wb_req.dat[1:0] == 2'h3) |-> ##[0:2] analog_on) else $error("analog block not powered");
  a_svc_pulse: assert property (service_req0 |=> !service_req0)
    else $error("service request longer than one cycle");
  a_buf_in_sample: assert property (buf_drive |-> sampling)
    else $error("buffer drive outside sample phase");
  a_buf_length: assert property ($fell(buf_drive) |->
    (buf_cnt_q == 6'h08 || buf_cnt_q == 6'h10 || buf_cnt_q == 6'h20))
    else $error("buffered phase length wrong");
  a_direct_phase: assert property ($fell(buf_drive) |-> sampling)
    else $error("sampling stopped with buffer phase");
  a_samp_powered: assert property (sampling |-> analog_on)
    else $error("sampling while analog block off");
endmodule

bind ecm_group ecm_group_sva u_sva (
  .clock        (clock),
  .nrst         (nrst),
  .wb_req       (wb_req),
  .wb_ack_o     (wb_ack_o),
  .analog_on    (analog_on),
  .buf_drive    (buf_drive),
  .sampling     (sampling),
  .service_req0 (service_req0)
);

//--- verification/ecm_conv_model.sv
// converter front end model: new result pattern at each sample end
`timescale 1ns/1ps
module ecm_conv_model (
  input wire logic  clock,
  input wire logic  nrst,
  input wire logic  sampling,
  output logic [15:0] conv_data
);
  logic        samp_q;
  logic [15:0] dat_d;

  always_comb begin
    dat_d = (samp_q && !sampling) ? {conv_data[14:0], ~conv_data[15]} : conv_data;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      samp_q    <= 1'b0;
      conv_data <= 16'h5A3C;
    end else begin
      samp_q    <= sampling;
      conv_data <= dat_d;
    end
  end
endmodule

//--- verification/test_adc_group_init_and_fifo_access.sv
// self-checking bench of the converter group control block
`timescale 1ns/1ps
module test_adc_group_init_and_fifo_access;
  import ecm_pkg::*;
  logic        clock;
  logic        nrst;
  logic        ce;
  ecm_wb_req_s wb_req;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [15:0] conv_data;
  logic        analog_on;
  logic        buf_drive;
  logic        sampling;
  logic        service_req0;
  logic        irq;
  logic [31:0] rd;
  logic [15:0] exp_dat;
  int          lat;
  int          miscompares;
  int          compares;
  int          cycles;

  ecm_group u_dut (
    .clock(clock), .nrst(nrst), .ce(ce), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .conv_data(conv_data), .analog_on(analog_on),
    .buf_drive(buf_drive), .sampling(sampling), .service_req0(service_req0), .irq(irq));
  ecm_conv_model u_conv (
    .clock(clock), .nrst(nrst), .sampling(sampling), .conv_data(conv_data));

  // ============================================================
  // shared tasks
  always #2 clock = ~clock;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    lat = 0;
    @(posedge clock);
    while (wb_ack_o !== 1'b1 && lat < 100) begin
      @(posedge clock);
      lat++;
    end
    rd = wb_dat_o;
    wb_req <= '0;
    chk("bus answer", 32'h1, {31'h0, lat < 100});
  endtask

  task automatic settle();
    repeat (2) @(negedge clock);
  endtask

  task automatic wait_svc();
    int n;
    n = 0;
    while (service_req0 !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    exp_dat = conv_data;
    chk("service request", 32'h1, {31'h0, n < 2000});
  endtask

  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ============================================================
  // scenarios
  task automatic t_reset();
    chk("outputs after reset", 32'h0, {27'h0, analog_on, buf_drive, sampling, service_req0, irq});
    wb_xfer(1'b0, ECM_OFF_ANALOG_CFG, 32'h0);
    chk("analog cfg reset", ECM_RST_ANALOG, rd);
    chk("register latency", 32'h1, lat);
    wb_xfer(1'b1, 8'h30, 32'hFFFF_FFFF);
    wb_xfer(1'b0, 8'h30, 32'h0);
    chk("unmapped read", ECM_RST_ZERO, rd);
  endtask

  task automatic t_init();
    wb_xfer(1'b1, ECM_OFF_ANALOG_CFG, 32'h0030_0000);
    wb_xfer(1'b1, ECM_OFF_ARB_CFG, 32'h0000_0003);
    settle();
    chk("analog on", 32'h1, {31'h0, analog_on});
    repeat (ECM_WAKE_CYC) @(posedge clock);
    wb_xfer(1'b1, ECM_OFF_GLOBAL_CFG, 32'h8000_0000);
    wb_xfer(1'b0, ECM_OFF_ARB_CFG, 32'h0);
    chk("calibration active", 32'h1, {31'h0, rd[ECM_BIT_CAL_ACT]});
    wb_xfer(1'b1, ECM_OFF_ARB_PRIO, 32'h0100_0000);
    wb_xfer(1'b0, ECM_OFF_ARB_PRIO, 32'h0);
    chk("arb prio", 32'h0100_0000, rd);
    wb_xfer(1'b1, ECM_OFF_QMODE0, 32'h0000_0001);
    wb_xfer(1'b0, ECM_OFF_QMODE0, 32'h0);
    chk("queue mode", 32'h0000_0001, rd);
    wb_xfer(1'b1, ECM_OFF_ICLASS0, 32'h0000_0002);
    wb_xfer(1'b1, ECM_OFF_RCTRL0, 32'h8000_0000);
    wb_xfer(1'b1, ECM_OFF_IRQ_MASK, 32'h0000_0001);
    wb_xfer(1'b1, ECM_OFF_QINPUT0, 32'h0000_0020);
    chk("held off in calibration", 32'h0, {31'h0, sampling});
    do begin
      wb_xfer(1'b0, ECM_OFF_ARB_CFG, 32'h0);
    end while (rd[ECM_BIT_CAL_ACT] !== 1'b0 && cycles < 20000);
    chk("calibration done", 32'h0, {31'h0, rd[ECM_BIT_CAL_ACT]});
  endtask

  task automatic t_result_irq();
    wait_svc();
    wb_xfer(1'b0, ECM_OFF_RESULT0, 32'h0);
    chk("result0", {16'h0, exp_dat}, {16'h0, rd[15:0]});
    chk("irq on result", 32'h1, {31'h0, irq});
    wb_xfer(1'b1, ECM_OFF_IRQ_MASK, 32'h0);
    settle();
    chk("irq masked", 32'h0, {31'h0, irq});
    wb_xfer(1'b1, ECM_OFF_IRQ_MASK, 32'h0000_0002);
    settle();
    chk("irq cal done", 32'h1, {31'h0, irq});
    wb_xfer(1'b1, ECM_OFF_IRQ_STAT, 32'h0000_0002);
    settle();
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask

  task automatic t_fifo();
    wait_svc();
    wb_xfer(1'b0, ECM_OFF_FIFO, 32'h0);
    chk("fifo latency", ECM_FIFO_LAT_CYC, lat);
    repeat (ECM_FIFO_GAP_CYC) @(posedge clock);
    wb_xfer(1'b0, ECM_OFF_FIFO, 32'h0);
    chk("fifo latency again", ECM_FIFO_LAT_CYC, lat);
  endtask

  task automatic t_buffer();
    int n;
    logic [5:0] exp;
    for (int i = 0; i < 3; i++) begin
      exp = (i == 0) ? ECM_PRE_8 : (i == 1) ? ECM_PRE_16 : ECM_PRE_32;
      wb_xfer(1'b1, ECM_OFF_ICLASS0, 32'h0000_041F | (i << ECM_LSB_AIP));
      n = 0;
      while (buf_drive === 1'b1 && n < 500) begin
        @(negedge clock);
        n++;
      end
      while (buf_drive !== 1'b1 && n < 500) begin
        @(negedge clock);
        n++;
      end
      n = 0;
      while (buf_drive === 1'b1 && n < 100) begin
        @(negedge clock);
        n++;
      end
      chk("precharge length", {26'h0, exp}, n);
      chk("direct sampling", 32'h1, {31'h0, sampling});
    end
  endtask

  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    ce = 1'b1;
    wb_req = '0;
    miscompares = 0;
    compares = 0;
    cycles = 0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_init();
    t_result_irq();
    t_fifo();
    t_buffer();
    print_verdict();
  end
endmodule
